// *** src/general_purpose_timer_counter.sv ***
/*
 * General purpose timer/counter: several independent 32-bit channels,
 * each with count clock, gate and direction pins and a pulse output,
 * reached through a simple strobe register port.
 * Assumes one 250 MHz clock, pins slower than that clock, and a master
 * that never raises read and write strobes together.
 */
// Contract
// - Up to four independent channels with own pins.
// - Count clock internal (33 MHz) or external (8 MHz).
// - Direction from pin or from software.
// - Gate from pin or from software.
// - Clock, gate, output polarity set by software.
// - Software loads initial count before counting.
// - Count readable anytime without disturbing operation.
// - PWM parameters change while running, uninterrupted.
// - Three inputs each: clock, gate, direction.
// - Each active clock edge steps counter by one.
// - Direction high counts up, low down.
// - Gate acts as level enable or trigger.
// - Output pulses shaped by selected mode.
// - Nothing runs before a software start.
// - Software reset clears status, reloads, halts.
// - PWM period low plus high; duty high/sum.
`timescale 1ns/1ps
`default_nettype none

module general_purpose_timer_counter #(
    parameter int NUM_CH = general_timer_pkg::NUM_CH_DEF
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    input wire general_timer_pkg::reg_req_s reg_req,
    output logic [general_timer_pkg::DATA_W-1:0] read_data,
    input wire logic [NUM_CH-1:0] count_clock_input,
    input wire logic [NUM_CH-1:0] count_gate_input,
    input wire logic [NUM_CH-1:0] count_direction_input,
    output logic [NUM_CH-1:0] counter_pulse_output
);
    import general_timer_pkg::*;

    // Block state, apart from the pin synchronisers, in one record
    typedef struct packed {
        chan_s [NUM_CH-1:0] ch;   // Channel records
        logic [PRESC_W-1:0] presc; // Internal timebase divider
        logic int_tick;            // One-cycle internal count tick
        logic [DATA_W-1:0] rdata;  // Read answer, valid one cycle
    } state_s;

    state_s state_reg;
    state_s state_next;

    // Synchronised pin views; clock and gate polarised
    logic [NUM_CH-1:0] clk_edge; // Active count clock edge
    logic [NUM_CH-1:0] gate_lvl; // Gate pin, active level
    logic [NUM_CH-1:0] dir_lvl;  // Direction pin level

    // One synchroniser per pin per channel
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        input_sync_edge u_clk (
            .mclk(mclk),
            .arst_n(arst_n),
            .ce(ce),
            .raw(count_clock_input[g]),
            .pol(state_reg.ch[g].ctrl.clk_pol),
            .level(),
            .rise(clk_edge[g])
        );
        input_sync_edge u_gate (
            .mclk(mclk),
            .arst_n(arst_n),
            .ce(ce),
            .raw(count_gate_input[g]),
            .pol(state_reg.ch[g].ctrl.gate_pol),
            .level(gate_lvl[g]),
            .rise()
        );
        input_sync_edge u_dir (
            .mclk(mclk),
            .arst_n(arst_n),
            .ce(ce),
            .raw(count_direction_input[g]),
            .pol(1'b0),
            .level(dir_lvl[g]),
            .rise()
        );
        // Output pin straight from its flop
        assign counter_pulse_output[g] = state_reg.ch[g].pin;
    end

    assign read_data = state_reg.rdata;

    // Next-state logic for every channel and the register port
    always_comb begin
        logic tick;              // Selected count clock edge
        logic up;                // Selected direction
        logic gl;                // Selected gate level
        logic ge;                // Gate became active
        logic adv;               // Gate allows a pulse mode to advance
        logic cont;              // Mode repeats its pulse
        logic [CNT_W-1:0] step;  // Counter after one step
        logic [CNT_W:0] nxt;     // Phase counter plus one, with carry
        logic [CH_W-1:0] sel;    // Addressed channel
        logic [OFF_W-1:0] off;   // Addressed register
        logic hit;               // Address lands on a present channel
        tick = 1'b0;
        up = 1'b0;
        gl = 1'b0;
        ge = 1'b0;
        adv = 1'b0;
        cont = 1'b0;
        step = '0;
        nxt = '0;
        sel = '0;
        off = '0;
        hit = 1'b0;
        state_next = state_reg;

        // Internal timebase: one tick every INT_DIV cycles keeps the
        // internal count rate under its ceiling
        state_next.int_tick = 1'b0;
        if (state_reg.presc == PRESC_W'(INT_DIV - 1)) begin
            state_next.presc = '0;
            state_next.int_tick = 1'b1;
        end else begin
            state_next.presc = state_reg.presc + PRESC_W'(1);
        end

        for (int i = 0; i < NUM_CH; i++) begin
            // Source selection per channel
            tick = state_reg.ch[i].ctrl.clk_ext ? clk_edge[i]
                                                : state_reg.int_tick;
            up = state_reg.ch[i].ctrl.dir_hw ? dir_lvl[i]
                                             : state_reg.ch[i].ctrl.sw_dir;
            gl = state_reg.ch[i].ctrl.gate_hw ? gate_lvl[i]
                                              : state_reg.ch[i].ctrl.sw_gate;
            ge = gl & ~state_reg.ch[i].gate_prev;
            state_next.ch[i].gate_prev = gl;
            // Plain 32-bit add wraps around on its own
            step = up ? state_reg.ch[i].count + CNT_W'(1)
                      : state_reg.ch[i].count - CNT_W'(1);
            nxt = {1'b0, state_reg.ch[i].count} + (CNT_W+1)'(1);
            adv = 1'b1;
            if (state_reg.ch[i].ctrl.mode == MODE_GATED_ONE ||
                state_reg.ch[i].ctrl.mode == MODE_GATED_CONT) begin
                adv = gl;
            end
            cont = state_reg.ch[i].ctrl.mode == MODE_TRIG_CONT ||
                   state_reg.ch[i].ctrl.mode == MODE_GATED_CONT ||
                   state_reg.ch[i].ctrl.mode == MODE_PWM;

            // Nothing moves until started
            if (state_reg.ch[i].running) begin
                case (state_reg.ch[i].phase)
                    PH_WAIT: begin
                        // Period and width wait for the gate; the
                        // triggered pulse modes start on its edge
                        if (ge) begin
                            if (state_reg.ch[i].ctrl.mode == MODE_PERIOD ||
                                state_reg.ch[i].ctrl.mode == MODE_PWIDTH) begin
                                state_next.ch[i].phase = PH_MEAS;
                                if (state_reg.ch[i].ctrl.mode == MODE_PWIDTH && tick) begin
                                    state_next.ch[i].count = step;
                                end
                            end else begin
                                state_next.ch[i].phase = PH_DELAY;
                                state_next.ch[i].count = '0;
                            end
                        end
                    end
                    PH_MEAS: begin
                        case (state_reg.ch[i].ctrl.mode)
                            MODE_PERIOD: begin
                                if (tick) begin
                                    state_next.ch[i].count = step;
                                end
                                // Second gate edge closes the period
                                if (ge) begin
                                    state_next.ch[i].done = 1'b1;
                                    state_next.ch[i].out = 1'b1;
                                    state_next.ch[i].running = 1'b0;
                                    state_next.ch[i].phase = PH_IDLE;
                                end
                            end
                            MODE_PWIDTH: begin
                                if (gl && tick) begin
                                    state_next.ch[i].count = step;
                                end
                                // Gate going inactive ends the width
                                if (!gl) begin
                                    state_next.ch[i].done = 1'b1;
                                    state_next.ch[i].out = 1'b1;
                                    state_next.ch[i].running = 1'b0;
                                    state_next.ch[i].phase = PH_IDLE;
                                end
                            end
                            default: begin
                                // Gated event counting: gate is a level enable
                                if (gl && tick) begin
                                    state_next.ch[i].count = step;
                                end
                            end
                        endcase
                    end
                    PH_DELAY: begin
                        // Low phase; live length compare lets PWM change on the fly
                        if (tick && adv) begin
                            if (nxt >= {1'b0, state_reg.ch[i].init}) begin
                                state_next.ch[i].phase = PH_HIGH;
                                state_next.ch[i].count = '0;
                                state_next.ch[i].out = 1'b1;
                            end else begin
                                state_next.ch[i].count = nxt[CNT_W-1:0];
                            end
                        end
                    end
                    PH_HIGH: begin
                        if (tick && adv) begin
                            if (nxt >= {1'b0, state_reg.ch[i].len}) begin
                                state_next.ch[i].out = 1'b0;
                                state_next.ch[i].count = '0;
                                if (cont) begin
                                    state_next.ch[i].phase = PH_DELAY;
                                end else if (state_reg.ch[i].ctrl.mode == MODE_RETRIG) begin
                                    // Edges seen during the pulse were ignored
                                    state_next.ch[i].phase = PH_WAIT;
                                end else begin
                                    state_next.ch[i].phase = PH_IDLE;
                                    state_next.ch[i].running = 1'b0;
                                    state_next.ch[i].done = 1'b1;
                                end
                            end else begin
                                state_next.ch[i].count = nxt[CNT_W-1:0];
                            end
                        end
                    end
                    default: begin
                        state_next.ch[i].phase = PH_IDLE;
                    end
                endcase
            end
        end

        // Register port decode
        sel = reg_req.addr[CH_LSB +: CH_W];
        off = reg_req.addr[OFF_W-1:0];
        hit = (reg_req.addr[ADDR_W-1:CH_LSB+CH_W] == '0) &&
              (32'(sel) < 32'(NUM_CH));

        // Writes; commands act after the channel update so they win
        if (reg_req.wr && hit) begin
            case (off)
                OFF_CTRL: begin
                    state_next.ch[sel].ctrl = reg_req.wdata;
                    state_next.ch[sel].ctrl.rsvd = '0;
                end
                OFF_INIT: begin
                    state_next.ch[sel].init = reg_req.wdata;
                end
                OFF_LEN: begin
                    state_next.ch[sel].len = reg_req.wdata;
                end
                OFF_CMD: begin
                    if (reg_req.wdata[CMD_RESET]) begin
                        // Reset has priority over a start in the same write
                        state_next.ch[sel].running = 1'b0;
                        state_next.ch[sel].done = 1'b0;
                        state_next.ch[sel].out = 1'b0;
                        state_next.ch[sel].phase = PH_IDLE;
                        state_next.ch[sel].count = state_reg.ch[sel].init;
                    end else if (reg_req.wdata[CMD_START]) begin
                        state_next.ch[sel].running = 1'b1;
                        state_next.ch[sel].done = 1'b0;
                        state_next.ch[sel].out = 1'b0;
                        case (state_reg.ch[sel].ctrl.mode)
                            MODE_EVENT: begin
                                state_next.ch[sel].count = state_reg.ch[sel].init;
                                state_next.ch[sel].phase = PH_MEAS;
                            end
                            MODE_PERIOD, MODE_PWIDTH: begin
                                state_next.ch[sel].count = state_reg.ch[sel].init;
                                state_next.ch[sel].phase = PH_WAIT;
                            end
                            MODE_TRIG_ONE, MODE_RETRIG, MODE_TRIG_CONT: begin
                                state_next.ch[sel].count = '0;
                                state_next.ch[sel].phase = PH_WAIT;
                            end
                            default: begin
                                state_next.ch[sel].count = '0;
                                state_next.ch[sel].phase = PH_DELAY;
                            end
                        endcase
                    end
                end
                default: begin
                    // Read-only or unmapped: write ignored
                end
            endcase
        end

        // Reads never touch channel state; answer stands one cycle only
        state_next.rdata = '0;
        if (reg_req.rd && hit) begin
            case (off)
                OFF_CTRL: state_next.rdata = state_reg.ch[sel].ctrl;
                OFF_INIT: state_next.rdata = state_reg.ch[sel].init;
                OFF_LEN: state_next.rdata = state_reg.ch[sel].len;
                OFF_COUNT: state_next.rdata = state_reg.ch[sel].count;
                OFF_STAT: begin
                    state_next.rdata[STAT_RUNNING] = state_reg.ch[sel].running;
                    state_next.rdata[STAT_DONE] = state_reg.ch[sel].done;
                    state_next.rdata[STAT_OUT] = state_reg.ch[sel].out;
                    state_next.rdata[STAT_PHASE_LSB +: 3] = state_reg.ch[sel].phase;
                end
                default: state_next.rdata = '0;
            endcase
        end

        // Pin levels follow the final logical output and polarity
        for (int i = 0; i < NUM_CH; i++) begin
            state_next.ch[i].pin = state_next.ch[i].out ^
                                   state_next.ch[i].ctrl.out_pol;
        end
    end

    // State register; clock enable low freezes everything
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                state_reg.ch[i].ctrl <= CTRL_RST;
                state_reg.ch[i].init <= INIT_RST;
                state_reg.ch[i].len <= LEN_RST;
            end
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

endmodule

`default_nettype wire

// *** src/general_timer_pkg.sv ***
/*
 * Shared definitions for the general purpose timer/counter block:
 * register offsets, control field layout, mode and phase codes,
 * the register port carrier and the internal timebase constants.
 * Assumes a single 250 MHz system clock and 32-bit register data.
 */
package general_timer_pkg;

    // Bus and counter widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 32;
    localparam int NUM_CH_DEF = 4;

    // Address split: channel select above, register offset below
    localparam int CH_LSB = 5;
    localparam int CH_W = 2;
    localparam int OFF_W = 5;

    // Per-channel register offsets (byte addresses inside a 0x20 window)
    localparam logic [OFF_W-1:0] OFF_CTRL = 5'h00;
    localparam logic [OFF_W-1:0] OFF_INIT = 5'h04;
    localparam logic [OFF_W-1:0] OFF_LEN = 5'h08;
    localparam logic [OFF_W-1:0] OFF_COUNT = 5'h0c;
    localparam logic [OFF_W-1:0] OFF_STAT = 5'h10;
    localparam logic [OFF_W-1:0] OFF_CMD = 5'h14;

    // Command register bit positions (write-only pulses)
    localparam int CMD_START = 0;
    localparam int CMD_RESET = 1;

    // Status register bit positions
    localparam int STAT_RUNNING = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_OUT = 2;
    localparam int STAT_PHASE_LSB = 4;

    // Reset values
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] INIT_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] LEN_RST = 32'h0000_0000;

    // Internal count clock: fastest rate allowed and the divider that meets it
    localparam int MCLK_MHZ = 250;
    localparam int INT_CLK_MAX_MHZ = 33;
    localparam int INT_DIV = (MCLK_MHZ + INT_CLK_MAX_MHZ - 1) / INT_CLK_MAX_MHZ;
    localparam int PRESC_W = 8;

    // Operating modes of one channel
    typedef enum logic [3:0] {
        MODE_EVENT = 4'h0,      // Gated event counting
        MODE_PERIOD = 4'h1,     // Single period measurement
        MODE_PWIDTH = 4'h2,     // Single pulse-width measurement
        MODE_GATED_ONE = 4'h3,  // Single gated pulse
        MODE_TRIG_ONE = 4'h4,   // Single triggered pulse
        MODE_RETRIG = 4'h5,     // Re-triggered single pulse
        MODE_TRIG_CONT = 4'h6,  // Single triggered continuous pulses
        MODE_GATED_CONT = 4'h7, // Continuous gated pulses
        MODE_PWM = 4'h8         // PWM, parameters changeable on the fly
    } mode_e;

    // Sequencer phase of one channel
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,  // Halted
        PH_WAIT = 3'b001,  // Waiting for a gate edge
        PH_DELAY = 3'b010, // Low phase of a pulse
        PH_HIGH = 3'b011,  // High phase of a pulse
        PH_MEAS = 3'b100   // Counting / measuring
    } phase_e;

    // Control register layout, bit 0 at the bottom
    typedef struct packed {
        logic [19:0] rsvd;  // Read as zero
        logic out_pol;      // 1: output active low
        logic gate_pol;     // 1: gate active low / falling edge
        logic clk_pol;      // 1: count on falling edge
        logic sw_gate;      // Software gate level
        logic gate_hw;      // 1: gate from pin
        logic sw_dir;       // Software direction, 1 counts up
        logic dir_hw;       // 1: direction from pin
        logic clk_ext;      // 1: count clock from pin
        mode_e mode;        // Operating mode
    } ctrl_s;

    // Register port request, all fields valid in one cycle
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    // State of one channel
    typedef struct packed {
        ctrl_s ctrl;
        logic [CNT_W-1:0] init;   // Initial count, or low-phase length
        logic [CNT_W-1:0] len;    // High-phase length
        logic [CNT_W-1:0] count;  // Live counter
        phase_e phase;
        logic running;
        logic done;
        logic out;                // Logical output before polarity
        logic gate_prev;          // Gate level one cycle earlier
        logic pin;                // Output pin level
    } chan_s;

endpackage

// *** src/input_sync_edge.sv ***
/*
 * Two-flop synchroniser for one external pin, with polarity applied
 * after synchronisation and an edge detector on the polarised level.
 * Assumes the pin is slow next to mclk (at most 8 MHz for count clocks).
 */
`timescale 1ns/1ps
`default_nettype none

module input_sync_edge (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic raw,
    input wire logic pol,
    output logic level,
    output logic rise
);
    // All state in one record
    typedef struct packed {
        logic sync1; // First stage, read only by the second
        logic sync2; // Settled copy of the pin
        logic prev;  // Settled copy one cycle older
    } sync_s;

    sync_s state_reg;
    sync_s state_next;

    // Shift chain; polarity is applied after this, so a change of
    // polarity flips both taps together and never fakes an edge
    always_comb begin
        state_next = state_reg;
        state_next.sync1 = raw;
        state_next.sync2 = state_reg.sync1;
        state_next.prev = state_reg.sync2;
    end

    // Registers, frozen while the clock enable is low
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign level = state_reg.sync2 ^ pol;
    assign rise = (state_reg.sync2 ^ pol) & ~(state_reg.prev ^ pol);

endmodule

`default_nettype wire

// *** test/timer_port_checker.sv ***
/* Port checker for the timer block: read answers and channel 0 read-back.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module timer_port_checker #(parameter int NUM_CH = 4) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    input wire general_timer_pkg::reg_req_s reg_req,
    input wire logic [general_timer_pkg::DATA_W-1:0] read_data,
    input wire logic [NUM_CH-1:0] counter_pulse_output
);
    import general_timer_pkg::*;
    logic [31:0] init_reg; // Shadow of channel 0 initial count
    logic [31:0] len_reg; // Shadow of channel 0 high length
    // Mirror writes so read-back is judged without peeking inside
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            init_reg <= INIT_RST;
            len_reg <= LEN_RST;
        end else if (ce && reg_req.wr) begin
            if (reg_req.addr == 8'h04) init_reg <= reg_req.wdata;
            if (reg_req.addr == 8'h08) len_reg <= reg_req.wdata;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_idle; $past(ce && !reg_req.rd) |-> read_data == '0; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_high; $past(ce && reg_req.rd && reg_req.addr[7]) |-> read_data == '0; endproperty
    a_high: assert property (p_high) else $error("high address answered");
    property p_gap; $past(ce && reg_req.rd && reg_req.addr[4:0] >= 5'h18) |-> read_data == '0;
    endproperty
    a_gap: assert property (p_gap) else $error("unmapped offset answered");
    property p_ctrl; $past(ce && reg_req.rd && reg_req.addr[4:0] == OFF_CTRL)
        |-> read_data[31:12] == '0; endproperty
    a_ctrl: assert property (p_ctrl) else $error("control spare bits set");
    property p_stat; $past(ce && reg_req.rd && reg_req.addr[4:0] == OFF_STAT)
        |-> read_data[31:7] == '0 && !read_data[3]; endproperty
    a_stat: assert property (p_stat) else $error("status spare bits set");
    property p_init; $past(ce && reg_req.rd && reg_req.addr == 8'h04)
        |-> read_data == $past(init_reg); endproperty
    a_init: assert property (p_init) else $error("initial count lost");
    property p_len; $past(ce && reg_req.rd && reg_req.addr == 8'h08)
        |-> read_data == $past(len_reg); endproperty
    a_len: assert property (p_len) else $error("high length lost");
    property p_quiet; $rose(arst_n) |-> counter_pulse_output == '0; endproperty
    a_quiet: assert property (p_quiet) else $error("output active before start");
endmodule
bind general_purpose_timer_counter timer_port_checker #(.NUM_CH(NUM_CH)) chk (.mclk(mclk),
    .arst_n(arst_n), .ce(ce), .reg_req(reg_req), .read_data(read_data),
    .counter_pulse_output(counter_pulse_output));
`default_nettype wire

// *** test/timer_pin_model.sv ***
/* Pin model around the timer: count clocks, gates and direction.
   Assumes the bench calls its task between register accesses. */
`timescale 1ns/1ps
`default_nettype none
module timer_pin_model (
    input wire logic mclk,
    output logic [3:0] clk_pin,
    output logic [3:0] gate_pin,
    output logic [3:0] dir_pin
);
    // All pins low; the count clock stands still between bursts
    initial begin
        clk_pin = '0;
        gate_pin = '0;
        dir_pin = '0;
    end
    // Three cycles each side, so the synchroniser never misses an edge
    task automatic pulse(input int ch, input int n);
        repeat (n) begin
            repeat (3) @(posedge mclk);
            clk_pin[ch] <= 1'b1;
            repeat (3) @(posedge mclk);
            clk_pin[ch] <= 1'b0;
        end
        repeat (6) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// *** test/general_purpose_timer_counter_bench.sv ***
/* Bench for the timer: register rows, counting, reset, PWM timing.
   Assumes the pin model drives the pins and the checker is bound. */
`timescale 1ns/1ps
`default_nettype none
module general_purpose_timer_counter_bench;
    import general_timer_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    reg_req_s req = '0;
    logic [31:0] read_data;
    logic [3:0] clk_pin, gate_pin, dir_pin, pulse_out;
    int fails = 0;
    int check_count = 0;
    int n;
    // Write, read-back pairs; spare, read-only and unmapped places included
    row_s rows [9] = '{{8'h60, 32'hffff_ffff, 32'h0000_0fff}, {8'h24, 32'h1234_5678, 32'h1234_5678},
        {8'h48, 32'hffff_ffff, 32'hffff_ffff}, {8'h6c, 32'h0000_0009, 32'h0}, {8'h70, 32'h7f, 32'h0},
        {8'h98, 32'h0000_0001, 32'h0}, {8'h1c, 32'h0000_0001, 32'h0}, {8'h04, 32'h5, 32'h5},
        {8'h08, 32'h3, 32'h3}};
    always #2 mclk = ~mclk;
    general_purpose_timer_counter dut (.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .reg_req(req),
        .read_data(read_data), .count_clock_input(clk_pin), .count_gate_input(gate_pin),
        .count_direction_input(dir_pin), .counter_pulse_output(pulse_out));
    timer_pin_model pins (.mclk(mclk), .clk_pin(clk_pin), .gate_pin(gate_pin), .dir_pin(dir_pin));
    task automatic finish_test();
        if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1 check(read_data, e);
    endtask
    // Cycles the PWM pin stays at one level; a stuck pin ends the run
    task automatic span(input logic lvl, output int c);
        c = 0;
        while (pulse_out[1] === lvl) begin
            @(posedge mclk);
            #1 c++;
            if (c > 300) begin
                fails++;
                $display("Error at %0t: pin stuck", $time);
                finish_test();
            end
        end
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        check({31'h0, pulse_out[3]}, 32'h1);
        wr(8'h00, 32'h150);
        wr(8'h14, 32'h1);
        pins.pulse(0, 3);
        rd(8'h0c, 32'h8);
        wr(8'h00, 32'h130);
        pins.pulse(0, 9);
        rd(8'h0c, 32'hffff_ffff);
        rd(8'h0c, 32'hffff_ffff);
        wr(8'h00, 32'h030);
        pins.pulse(0, 2);
        rd(8'h0c, 32'hffff_ffff);
        wr(8'h14, 32'h2);
        rd(8'h10, 32'h0);
        wr(8'h00, 32'h130);
        pins.pulse(0, 1);
        rd(8'h0c, 32'h5);
        pins.dir_pin[0] <= 1'b1;
        wr(8'h14, 32'h1);
        pins.pulse(0, 2);
        rd(8'h0c, 32'h7);
        wr(8'h20, 32'h8);
        wr(8'h24, 32'h2);
        wr(8'h28, 32'h3);
        wr(8'h34, 32'h1);
        for (int k = 0; k < 2; k++) begin
            span(1'b1, n);
            span(1'b0, n);
            span(1'b1, n);
            check(n, k ? 32'd8 : 32'd24);
            span(1'b0, n);
            check(n, 32'd16);
            wr(8'h28, 32'h1);
        end
        finish_test();
    end
endmodule
`default_nettype wire
